/* hw/fpsh_map.svh */
// register offsets, field positions and encodings for the fp store/sub/hint decoder
`ifndef FPSH_MAP_SVH
`define FPSH_MAP_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define FPSH_OFF_INSTR    12'h000
`define FPSH_OFF_CTRL     12'h004
`define FPSH_OFF_BASE     12'h008
`define FPSH_OFF_FPLO     12'h00C
`define FPSH_OFF_FPHI     12'h010
`define FPSH_OFF_STATUS   12'h014
`define FPSH_OFF_ISTAT    12'h018
`define FPSH_OFF_IEN      12'h01C
`define FPSH_OFF_ICLR     12'h020
`define FPSH_OFF_ADDR     12'h024
`define FPSH_OFF_OPS      12'h028
// ----------------------------------------------------------------
// ctrl bits
// ----------------------------------------------------------------
`define FPSH_CTRL_GO      0
`define FPSH_CTRL_HAVE_FP 1
`define FPSH_CTRL_SP_ONLY 2
`define FPSH_CTRL_MAIN    3
`define FPSH_CTRL_COND    4
`define FPSH_CTRL_BIGEND  5
`define FPSH_CTRL_EVENT   6
`define FPSH_CTRL_FPFAULT 7
`define FPSH_CTRL_WAKE    8
`define FPSH_CTRL_BUSERR  9
`define FPSH_CTRL_RESET   32'h0000_000A
// ----------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------
`define FPSH_EV_DONE      0
`define FPSH_EV_UNDEF     1
`define FPSH_EV_FAULT     2
`define FPSH_EV_SLEEP     3
`define FPSH_EV_WIDTH     4
// ----------------------------------------------------------------
// instruction patterns
// ----------------------------------------------------------------
`define FPSH_STR_MASK     32'hFF30_0E00
`define FPSH_STR_PAT      32'hED00_0A00
`define FPSH_SUB_MASK     32'hFFB0_0E50
`define FPSH_SUB_PAT      32'hEE30_0A40
`define FPSH_T16_WFE      16'hBF20
`define FPSH_T16_WFI      16'hBF30
`define FPSH_T16_YIELD    16'hBF10
`define FPSH_T32_HINT_MSK 32'hFFF0_FF00
`define FPSH_T32_HINT_PAT 32'hF3A0_8000
`define FPSH_HINT_YIELD   8'h01
`define FPSH_HINT_WFE     8'h02
`define FPSH_HINT_WFI     8'h03
`define FPSH_PC_REG       4'hF
`endif

/* hw/fpsh_pkg.sv */
// types for the fp store/sub/hint decoder
package fpsh_pkg;
   typedef enum logic [5:0] {
      FPSH_IDLE  = 6'b00_0001,
      FPSH_WR0   = 6'b00_0010,
      FPSH_WR1   = 6'b00_0100,
      FPSH_SUBX  = 6'b00_1000,
      FPSH_SLEEP = 6'b01_0000,
      FPSH_RESP  = 6'b10_0000
   } fpsh_state_t;
endpackage

/* hw/fpsh_decode.sv */
// fp store, fp subtract and hint decoder with axi4-lite control and store master
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`include "fpsh_map.svh"

// Functional notes
// - no fp extension makes stores/subtract undefined
// - double store index extra bit on top
// - single store index extra bit at bottom
// - sign flag chooses base plus or minus
// - offset multiple of four, 0 to 1020
// - single store writes one aligned word
// - double store two words, endian ordered
// - failed condition completes without effect
// - store/sub fault, hints never fault
// - precision select, double subtract undefined if single-only
// - subtract indices ordered by precision
// - subtract only records its operand indices, writes no result
// - event hint clears event or sleeps
// - interrupt hint sleeps until wake or event
// - yield treated as no-operation here
// - hints decode as no-operation compatible
// - wide hints undefined without main extension
module fpsh_decode (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [11:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic [31:0] st_addr,
   output logic [31:0] st_data,
   output logic st_valid,
   input wire logic st_ready,
   output logic irq
);
   import fpsh_pkg::*;

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   logic [31:0] instr_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] base_reg;
   logic [31:0] fplo_reg;
   logic [31:0] fphi_reg;
   logic [31:0] addr_reg;
   logic [31:0] ops_reg;
   logic [`FPSH_EV_WIDTH-1:0] istat_reg;
   logic [`FPSH_EV_WIDTH-1:0] ien_reg;
   logic [`FPSH_EV_WIDTH-1:0] ev_pulse;
   logic event_reg;
   fpsh_state_t state_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [11:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic wr_fire;
   logic go;
   logic [3:0] icl_next;

   assign wr_fire = aw_held_reg && w_held_reg && !s_bvalid;
   assign go = wr_fire && awaddr_reg == `FPSH_OFF_CTRL && wstrb_reg[0]
      && wdata_reg[`FPSH_CTRL_GO];

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic is_str, is_sub, is_dbl, up;
   logic h16_wfe, h16_wfi, h16_yld, h32, h32_wfe, h32_wfi, h32_yld;
   logic [4:0] str_idx, sub_d, sub_n, sub_m;
   logic [31:0] imm32, ea;
   logic undef;
   assign is_str = (instr_reg & `FPSH_STR_MASK) == `FPSH_STR_PAT;
   assign is_sub = (instr_reg & `FPSH_SUB_MASK) == `FPSH_SUB_PAT;
   assign is_dbl = instr_reg[8];
   assign up = instr_reg[23];
   assign str_idx = is_dbl ? {instr_reg[22], instr_reg[15:12]}
      : {instr_reg[15:12], instr_reg[22]};
   assign imm32 = {22'h00_0000, instr_reg[7:0], 2'b00};
   assign ea = up ? base_reg + imm32 : base_reg - imm32;
   assign sub_d = is_dbl ? {instr_reg[22], instr_reg[15:12]}
      : {instr_reg[15:12], instr_reg[22]};
   assign sub_n = is_dbl ? {instr_reg[7], instr_reg[19:16]}
      : {instr_reg[19:16], instr_reg[7]};
   assign sub_m = is_dbl ? {instr_reg[5], instr_reg[3:0]}
      : {instr_reg[3:0], instr_reg[5]};
   assign h16_wfe = instr_reg[15:0] == `FPSH_T16_WFE && instr_reg[31:16] == 16'h0000;
   assign h16_wfi = instr_reg[15:0] == `FPSH_T16_WFI && instr_reg[31:16] == 16'h0000;
   assign h16_yld = instr_reg[15:0] == `FPSH_T16_YIELD && instr_reg[31:16] == 16'h0000;
   assign h32 = (instr_reg & `FPSH_T32_HINT_MSK) == `FPSH_T32_HINT_PAT;
   assign h32_wfe = h32 && instr_reg[7:0] == `FPSH_HINT_WFE;
   assign h32_wfi = h32 && instr_reg[7:0] == `FPSH_HINT_WFI;
   assign h32_yld = h32 && instr_reg[7:0] == `FPSH_HINT_YIELD;
   always_comb begin
      undef = 1'b1;
      if (is_str || is_sub) begin
         undef = !ctrl_reg[`FPSH_CTRL_HAVE_FP];
         if (is_sub && is_dbl && ctrl_reg[`FPSH_CTRL_SP_ONLY]) begin
            undef = 1'b1;
         end
      end else if (h16_wfe || h16_wfi || h16_yld) begin
         undef = 1'b0;
      end else if (h32_wfe || h32_wfi || h32_yld) begin
         undef = !ctrl_reg[`FPSH_CTRL_MAIN];
      end
   end

   // ----------------------------------------------------------------
   // execution state machine
   // ----------------------------------------------------------------
   logic busy;
   assign busy = state_reg != FPSH_IDLE;
   always_ff @(posedge aclk) begin
      ev_pulse <= '0;
      if (!aresetn) begin
         state_reg <= FPSH_IDLE;
         st_valid <= 1'b0;
         st_addr <= 32'h0000_0000;
         st_data <= 32'h0000_0000;
         addr_reg <= 32'h0000_0000;
         ops_reg <= 32'h0000_0000;
         event_reg <= 1'b0;
      end else begin
         case (state_reg)
            FPSH_IDLE: begin
               if (go) begin
                  if (!wdata_reg[`FPSH_CTRL_COND]) begin
                     state_reg <= FPSH_RESP;
                  end else if (undef) begin
                     ev_pulse[`FPSH_EV_UNDEF] <= 1'b1;
                     state_reg <= FPSH_RESP;
                  end else if ((is_str || is_sub) && wdata_reg[`FPSH_CTRL_FPFAULT]) begin
                     ev_pulse[`FPSH_EV_FAULT] <= 1'b1;
                     state_reg <= FPSH_RESP;
                  end else if (is_str) begin
                     addr_reg <= ea;
                     ops_reg <= {16'h0000, is_dbl, str_idx, 10'h000};
                     st_addr <= {ea[31:2], 2'b00};
                     st_data <= (is_dbl && ctrl_reg[`FPSH_CTRL_BIGEND]) ? fphi_reg
                        : fplo_reg;
                     st_valid <= 1'b1;
                     state_reg <= is_dbl ? FPSH_WR0 : FPSH_WR1;
                  end else if (is_sub) begin
                     ops_reg <= {16'h0000, is_dbl, sub_d, sub_n, sub_m};
                     state_reg <= FPSH_SUBX;
                  end else if (h16_wfe || h32_wfe) begin
                     if (event_reg) begin
                        event_reg <= 1'b0;
                        state_reg <= FPSH_RESP;
                     end else begin
                        ev_pulse[`FPSH_EV_SLEEP] <= 1'b1;
                        state_reg <= FPSH_SLEEP;
                     end
                  end else if (h16_wfi || h32_wfi) begin
                     ev_pulse[`FPSH_EV_SLEEP] <= 1'b1;
                     state_reg <= FPSH_SLEEP;
                  end else begin
                     state_reg <= FPSH_RESP;
                  end
               end
            end
            FPSH_WR0: begin
               if (st_ready) begin
                  st_addr <= st_addr + 32'h0000_0004;
                  st_data <= ctrl_reg[`FPSH_CTRL_BIGEND] ? fplo_reg : fphi_reg;
                  state_reg <= FPSH_WR1;
               end
            end
            FPSH_WR1: begin
               if (st_ready) begin
                  st_valid <= 1'b0;
                  if (ctrl_reg[`FPSH_CTRL_BUSERR]) begin
                     ev_pulse[`FPSH_EV_FAULT] <= 1'b1;
                  end
                  state_reg <= FPSH_RESP;
               end
            end
            FPSH_SUBX: begin
               state_reg <= FPSH_RESP;
            end
            FPSH_SLEEP: begin
               if (ctrl_reg[`FPSH_CTRL_WAKE] || event_reg) begin
                  event_reg <= 1'b0;
                  state_reg <= FPSH_RESP;
               end
            end
            FPSH_RESP: begin
               ev_pulse[`FPSH_EV_DONE] <= 1'b1;
               state_reg <= FPSH_IDLE;
            end
            default: state_reg <= FPSH_IDLE;
         endcase
         // rising event bit on a ctrl write with byte 0 strobed, set wins over consume
         if (wr_fire && awaddr_reg == `FPSH_OFF_CTRL && wstrb_reg[0]
            && !ctrl_reg[`FPSH_CTRL_EVENT] && wdata_reg[`FPSH_CTRL_EVENT]) begin
            event_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite write side
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 12'h000;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         s_awready <= 1'b0;
         s_wready <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp <= 2'b00;
      end else begin
         s_awready <= !aw_held_reg && !s_awready && s_awvalid;
         s_wready <= !w_held_reg && !s_wready && s_wvalid;
         if (s_awvalid && s_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_wdata;
            wstrb_reg <= s_wstrb;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= (awaddr_reg > `FPSH_OFF_OPS || awaddr_reg[1:0] != 2'b00) ? 2'b10 : 2'b00;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // byte-lane merge of register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr_reg <= 32'h0000_0000;
         ctrl_reg <= `FPSH_CTRL_RESET;
         base_reg <= 32'h0000_0000;
         fplo_reg <= 32'h0000_0000;
         fphi_reg <= 32'h0000_0000;
         ien_reg <= '0;
      end else if (wr_fire) begin
         case (awaddr_reg)
            `FPSH_OFF_INSTR: if (!busy) instr_reg <= merge(instr_reg, wdata_reg, wstrb_reg);
            `FPSH_OFF_CTRL: ctrl_reg <= {merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_03FE};
            `FPSH_OFF_BASE: if (!busy) base_reg <= merge(base_reg, wdata_reg, wstrb_reg);
            `FPSH_OFF_FPLO: if (!busy) fplo_reg <= merge(fplo_reg, wdata_reg, wstrb_reg);
            `FPSH_OFF_FPHI: if (!busy) fphi_reg <= merge(fphi_reg, wdata_reg, wstrb_reg);
            `FPSH_OFF_IEN: if (wstrb_reg[0]) ien_reg <= wdata_reg[`FPSH_EV_WIDTH-1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // interrupts: set wins over clear
   // ----------------------------------------------------------------
   assign icl_next = (wr_fire && awaddr_reg == `FPSH_OFF_ICLR && wstrb_reg[0])
      ? wdata_reg[`FPSH_EV_WIDTH-1:0] : 4'h0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         istat_reg <= '0;
         irq <= 1'b0;
      end else begin
         istat_reg <= (istat_reg & ~icl_next) | ev_pulse;
         irq <= |(((istat_reg & ~icl_next) | ev_pulse) & ien_reg);
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read side
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (s_araddr)
         `FPSH_OFF_INSTR: rd_mux = instr_reg;
         `FPSH_OFF_CTRL: rd_mux = ctrl_reg;
         `FPSH_OFF_BASE: rd_mux = base_reg;
         `FPSH_OFF_FPLO: rd_mux = fplo_reg;
         `FPSH_OFF_FPHI: rd_mux = fphi_reg;
         `FPSH_OFF_STATUS: rd_mux = {25'h000_0000, event_reg, state_reg};
         `FPSH_OFF_ISTAT: rd_mux = {28'h000_0000, istat_reg};
         `FPSH_OFF_IEN: rd_mux = {28'h000_0000, ien_reg};
         `FPSH_OFF_ADDR: rd_mux = addr_reg;
         `FPSH_OFF_OPS: rd_mux = ops_reg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= 2'b00;
      end else begin
         s_arready <= s_arvalid && !s_arready && !s_rvalid;
         if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata <= rd_mux;
            s_rresp <= (s_araddr > `FPSH_OFF_OPS || s_araddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_dbl_order;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == FPSH_WR0 && st_valid && st_ready |=> st_addr == $past(st_addr) + 32'h4;
   endproperty
   a_dbl_order: assert property (p_dbl_order) else $error("second word not at plus four");
   property p_aligned;
      @(posedge aclk) disable iff (!aresetn) st_valid |-> st_addr[1:0] == 2'b00;
   endproperty
   a_aligned: assert property (p_aligned) else $error("store not aligned");
   property p_undef_no_store;
      @(posedge aclk) disable iff (!aresetn) ev_pulse[`FPSH_EV_UNDEF] |-> !st_valid;
   endproperty
   a_undef_no_store: assert property (p_undef_no_store) else $error("store on undef");
   property p_fault_first;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == FPSH_IDLE && go && wdata_reg[`FPSH_CTRL_COND] && !undef && is_str
      && wdata_reg[`FPSH_CTRL_FPFAULT] |=> !st_valid;
   endproperty
   a_fault_first: assert property (p_fault_first) else $error("store after check fault");
   property p_cond_fail;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == FPSH_IDLE && go && !wdata_reg[`FPSH_CTRL_COND] |=> state_reg == FPSH_RESP
      ##1 ev_pulse == 4'b0001;
   endproperty
   a_cond_fail: assert property (p_cond_fail) else $error("failed condition had effect");
   property p_wfe_clear;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == FPSH_IDLE && go && wdata_reg[`FPSH_CTRL_COND] && h16_wfe && event_reg
      |=> !event_reg && state_reg == FPSH_RESP;
   endproperty
   a_wfe_clear: assert property (p_wfe_clear) else $error("event not consumed");
   property p_wfi_sleep;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == FPSH_IDLE && go && wdata_reg[`FPSH_CTRL_COND] && h16_wfi
      |=> state_reg == FPSH_SLEEP;
   endproperty
   a_wfi_sleep: assert property (p_wfi_sleep) else $error("wfi did not sleep");
   property p_hint_no_fault;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == FPSH_IDLE && go && (h16_yld || h16_wfe || h16_wfi) |=> !ev_pulse[2];
   endproperty
   a_hint_no_fault: assert property (p_hint_no_fault) else $error("hint faulted");
   property p_wide_hint;
      @(posedge aclk) disable iff (!aresetn)
      h32_yld && !ctrl_reg[`FPSH_CTRL_MAIN] |-> undef;
   endproperty
   a_wide_hint: assert property (p_wide_hint) else $error("wide hint accepted");
endmodule

/* verification/fpsh_mem_model.sv */
// memory-side model that takes store words with a programmable stall
module fpsh_mem_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] st_addr,
   input wire logic [31:0] st_data,
   input wire logic st_valid,
   output logic st_ready,
   input wire logic [3:0] stall
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] addr_log [4];
   logic [31:0] data_log [4];
   int n_words = 0;
   logic [3:0] wait_cnt = 4'h0;
   // ----------------------------------------------------------------
   // word acceptance
   // ----------------------------------------------------------------
   // ready only answers a held request, one word per handshake
   always @(posedge aclk) begin
      if (!aresetn) begin
         st_ready <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (st_valid && st_ready) begin
         addr_log[n_words % 4] <= st_addr;
         data_log[n_words % 4] <= st_data;
         n_words <= n_words + 1;
         st_ready <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (st_valid && wait_cnt >= stall) begin
         st_ready <= 1'b1;
      end else if (st_valid) begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule

/* verification/tb.sv */
// self-checking bench for the fp store, subtract and hint decoder
`include "fpsh_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fpsh_pkg::*;
   localparam logic [31:0] CFG = 32'h0000_001A;
   localparam logic [31:0] LO = 32'hA5A5_0001;
   localparam logic [31:0] HI = 32'h5A5A_0002;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] s_awaddr = 12'h000;
   logic s_awvalid = 1'b0;
   logic [31:0] s_wdata = 32'h0000_0000;
   logic [3:0] s_wstrb = 4'h0;
   logic s_wvalid = 1'b0;
   logic s_bready = 1'b0;
   logic [11:0] s_araddr = 12'h000;
   logic s_arvalid = 1'b0;
   logic s_rready = 1'b0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, st_valid, st_ready, irq;
   logic [1:0] s_bresp, s_rresp, rs;
   logic [31:0] s_rdata, st_addr, st_data, rd;
   logic [3:0] stall = 4'h0;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   int w0 = 0;

   fpsh_decode u_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .st_addr(st_addr), .st_data(st_data), .st_valid(st_valid),
      .st_ready(st_ready), .irq(irq));
   fpsh_mem_model u_mem (.aclk(aclk), .aresetn(aresetn), .st_addr(st_addr),
      .st_data(st_data), .st_valid(st_valid), .st_ready(st_ready), .stall(stall));

   always #2 aclk = ~aclk;
   // ----------------------------------------------------------------
   // closing, timeout and comparison
   // ----------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         stop_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // ----------------------------------------------------------------
   // axi4-lite master
   // ----------------------------------------------------------------
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bit aw, w, b;
      int n;
      aw = 0; w = 0; b = 0; n = 0;
      s_awaddr <= a; s_awvalid <= 1'b1; s_wdata <= d; s_wstrb <= 4'hF;
      s_wvalid <= 1'b1; s_bready <= 1'b1;
      while (!b && n < 100) begin
         @(posedge aclk);
         n++;
         if (!aw && s_awready === 1'b1) begin aw = 1; s_awvalid <= 1'b0; end
         if (!w && s_wready === 1'b1) begin w = 1; s_wvalid <= 1'b0; end
         if (s_bvalid === 1'b1) begin b = 1; rs = s_bresp; end
      end
      s_bready <= 1'b0;
      if (!b) begin n_fail++; stop_test(); end
      @(posedge aclk);
   endtask
   task automatic rdreg(input logic [11:0] a);
      bit ar, r;
      int n;
      ar = 0; r = 0; n = 0;
      s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
      while (!r && n < 100) begin
         @(posedge aclk);
         n++;
         if (!ar && s_arready === 1'b1) begin ar = 1; s_arvalid <= 1'b0; end
         if (s_rvalid === 1'b1) begin r = 1; rd = s_rdata; rs = s_rresp; end
      end
      s_rready <= 1'b0;
      if (!r) begin n_fail++; stop_test(); end
      @(posedge aclk);
   endtask
   // ----------------------------------------------------------------
   // instruction helpers
   // ----------------------------------------------------------------
   // base field fixed at 3, never the program counter
   function automatic logic [31:0] str_ins(input bit u, input bit dbl, input logic [7:0] imm);
      return {8'hED, u, 1'b1, 2'b00, 4'h3, 4'h5, 3'b101, dbl, imm};
   endfunction
   function automatic logic [31:0] sub_ins(input bit sz);
      return {8'hEE, 1'b0, 1'b1, 2'b11, 4'h3, 4'h6, 3'b101, sz, 1'b0, 1'b1, 1'b1, 1'b0, 4'h9};
   endfunction
   task automatic run(input logic [31:0] ins, input logic [31:0] base, input logic [31:0] cfg);
      int n;
      wr(`FPSH_OFF_ICLR, 32'h0000_000F);
      wr(`FPSH_OFF_INSTR, ins);
      wr(`FPSH_OFF_BASE, base);
      wr(`FPSH_OFF_CTRL, cfg);
      w0 = u_mem.n_words;
      wr(`FPSH_OFF_CTRL, cfg | 32'h0000_0001);
      n = 0;
      rd = 32'h0000_0000;
      while (rd[3:0] === 4'h0 && n < 200) begin
         rdreg(`FPSH_OFF_ISTAT);
         n++;
      end
   endtask
   task automatic words(input int cnt, input logic [31:0] a, input logic [31:0] d0,
         input logic [31:0] d1);
      chk("word count", cnt, u_mem.n_words - w0);
      if (cnt > 0) begin
         chk("addr 0", a, u_mem.addr_log[w0 % 4]);
         chk("data 0", d0, u_mem.data_log[w0 % 4]);
      end
      if (cnt > 1) begin
         chk("addr 1", a + 4, u_mem.addr_log[(w0 + 1) % 4]);
         chk("data 1", d1, u_mem.data_log[(w0 + 1) % 4]);
      end
   endtask
   task automatic wake();
      wr(`FPSH_OFF_CTRL, CFG | 32'h0000_0100);
      repeat (4) @(posedge aclk);
      rdreg(`FPSH_OFF_STATUS);
      chk("woken state", {26'h0, FPSH_IDLE}, {26'h0, rd[5:0]});
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdreg(`FPSH_OFF_CTRL);
      chk("ctrl reset", `FPSH_CTRL_RESET, rd);
      rdreg(12'h100);
      chk("unmapped resp", 32'h0000_0002, {30'h0, rs});
      wr(12'h100, 32'h0000_0000);
      chk("unmapped write resp", 32'h0000_0002, {30'h0, rs});
      wr(`FPSH_OFF_FPLO, LO);
      wr(`FPSH_OFF_FPHI, HI);
      wr(`FPSH_OFF_IEN, 32'h0000_0001);
      stall <= 4'h2;
      run(str_ins(1, 0, 8'hFF), 32'h2000_0000, CFG);
      words(1, 32'h2000_03FC, LO, LO);
      rdreg(`FPSH_OFF_ADDR);
      chk("last addr", 32'h2000_03FC, rd);
      rdreg(`FPSH_OFF_OPS);
      chk("single store index", 32'h0000_2C00, rd);
      repeat (2) @(posedge aclk);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(`FPSH_OFF_IEN, 32'h0000_0000);
      repeat (2) @(posedge aclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      stall <= 4'h0;
      run(str_ins(0, 1, 8'h04), 32'h2000_0100, CFG);
      words(2, 32'h2000_00F0, LO, HI);
      rdreg(`FPSH_OFF_OPS);
      chk("double store index", 32'h0000_D400, rd);
      run(str_ins(1, 1, 8'h00), 32'h2000_0200, CFG | 32'h0000_0020);
      words(2, 32'h2000_0200, HI, LO);
      run(str_ins(1, 1, 8'h01), 32'h2000_0000, CFG & ~32'h0000_0010);
      words(0, 0, 0, 0);
      chk("cond fail status", 32'h1, {28'h0, rd[3:0]});
      run(str_ins(1, 1, 8'h01), 32'h2000_0000, CFG | 32'h0000_0080);
      words(0, 0, 0, 0);
      chk("fault status", 32'h1, {31'h0, rd[2]});
      run(str_ins(1, 0, 8'h01), 32'h2000_0000, CFG & ~32'h0000_0002);
      words(0, 0, 0, 0);
      chk("undef store", 32'h1, {31'h0, rd[1]});
      run(sub_ins(1'b0), 32'h0, CFG & ~32'h0000_0002);
      chk("undef sub", 32'h1, {31'h0, rd[1]});
      run(sub_ins(1'b0), 32'h0, CFG);
      rdreg(`FPSH_OFF_OPS);
      chk("ops single", {16'h0, 1'b0, 5'd13, 5'd6, 5'd19}, rd);
      run(sub_ins(1'b1), 32'h0, CFG);
      rdreg(`FPSH_OFF_OPS);
      chk("ops double", {16'h0, 1'b1, 5'd22, 5'd3, 5'd25}, rd);
      run(sub_ins(1'b1), 32'h0, CFG | 32'h0000_0004);
      chk("undef double", 32'h1, {31'h0, rd[1]});
      run({16'h0, `FPSH_T16_YIELD}, 32'h0, CFG);
      chk("yield status", 32'h1, {28'h0, rd[3:0]});
      wr(`FPSH_OFF_CTRL, CFG | 32'h0000_0040);
      run({16'h0, `FPSH_T16_WFE}, 32'h0, CFG | 32'h0000_0040);
      chk("event wait status", 32'h1, {28'h0, rd[3:0]});
      rdreg(`FPSH_OFF_STATUS);
      chk("event cleared", 32'h0, {31'h0, rd[6]});
      run({16'h0, `FPSH_T16_WFE}, 32'h0, CFG);
      chk("event sleep", 32'h8, {28'h0, rd[3:0]});
      rdreg(`FPSH_OFF_STATUS);
      chk("sleep state", {26'h0, FPSH_SLEEP}, {26'h0, rd[5:0]});
      wake();
      run({16'h0, `FPSH_T16_WFI}, 32'h0, CFG & ~32'h0000_0008);
      chk("narrow wfi sleep", 32'h8, {28'h0, rd[3:0]});
      wake();
      run(`FPSH_T32_HINT_PAT | 32'h000F_0003, 32'h0, CFG);
      chk("wide wfi sleep", 32'h8, {28'h0, rd[3:0]});
      wake();
      for (int h = 1; h <= 3; h++) begin
         run(`FPSH_T32_HINT_PAT | 32'h000F_0000 | h, 32'h0, CFG & ~32'h0000_0008);
         chk("wide hint undef", 32'h1, {31'h0, rd[1]});
      end
      stop_test();
   end
endmodule
